// *** mdl_conv_model.sv ***
// Behavioural model of the serial converters that sit behind the channel loader.
`timescale 1ns/1ns
`default_nettype none
module mdl_conv_model #(
	parameter int NUM_CH = 16
) (
	input  wire logic              clk_i,
	input  wire logic              rstn_i,
	input  wire logic              ser_data_i,
	input  wire logic              ser_bit_i,
	input  wire logic              ser_latch_i,
	input  wire logic [NUM_CH-1:0] dac_sel_i,
	input  wire logic              stall_i,
	output logic                   dac_ready_o,
	output logic [7:0]             frame_len_o,
	output logic [7:0]             bit_cnt_o
);
	logic [15:0] shift_q;
	logic [15:0] mem [NUM_CH];
	logic [7:0]  sel_cyc_q;
	logic [7:0]  bits_q;
	logic [3:0]  chan;

	// A stall holds the path busy so that words pile up in the loader's buffer.
	assign dac_ready_o = ~stall_i;

	// Channel number from the one-hot select; a broken select shows as a wrong channel.
	always_comb begin
		chan = 4'h0;
		for (int i = 0; i < NUM_CH; i++) begin
			if (dac_sel_i[i]) begin
				chan = i[3:0];
			end
		end
	end

	// Shift in MSB first, store the whole word per channel on the latch pulse.
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			shift_q     <= 16'h0000;
			bits_q      <= 8'h00;
			sel_cyc_q   <= 8'h00;
			frame_len_o <= 8'h00;
			bit_cnt_o   <= 8'h00;
		end else begin
			if (ser_bit_i) begin
				shift_q <= {shift_q[14:0], ser_data_i};
				bits_q  <= bits_q + 8'h01;
			end
			if (ser_latch_i) begin
				mem[chan] <= shift_q;
				bit_cnt_o <= bits_q;
				bits_q    <= 8'h00;
			end
			if (|dac_sel_i) begin
				sel_cyc_q <= sel_cyc_q + 8'h01;
			end else if (sel_cyc_q != 8'h00) begin
				frame_len_o <= sel_cyc_q;
				sel_cyc_q   <= 8'h00;
			end
		end
	end
endmodule : mdl_conv_model
`default_nettype wire

// *** mdl_dac_loader.sv ***
// Channel loader: decodes code writes, shifts each code to its converter and reports transfer status.
//
// Functional notes
// - Each channel code is 16-bit two's complement and is sent unchanged.
// - Code 0x8000 is minus full scale, 0x7FFF just below plus, zero is zero.
// - Positive codes up to 16384 pass untouched for a reduced unipolar span.
// - Eight or sixteen channels, each with its own writable code.
// - Every transfer lasts 2.2 microseconds and stays in progress for all of it.
// - Status reads one during a transfer and zero when none is in progress; here it also reads one while a written word waits in the buffer.
// - Current channel n is driven from voltage channel n.
// - One range setting serves all current channels together.
// - Range mode 1 is 0-20 mA, mode 2 is 4-20 mA, mode 3 is 5-25 mA.
// - Channel n is written at even byte offset two times n, for n up to fifteen.
// - Busy flag sits in bit zero of a read-only status word.
`timescale 1ns/1ns
`default_nettype none
`include "mdl_map.svh"
module mdl_dac_loader
	import mdl_pkg::*;
#(
	parameter int NUM_CH = `MDL_CHAN_MAX
) (
	input  wire logic                      clk_i,
	input  wire logic                      rstn_i,
	input  wire logic                      wr_valid_i,
	input  wire logic [`MDL_ADDR_W-1:0]    wr_addr_i,
	input  wire logic [`MDL_CODE_W-1:0]    wr_data_i,
	output logic                           wr_ready_o,
	input  wire logic                      dac_ready_i,
	output logic                           ser_data_o,
	output logic                           ser_bit_o,
	output logic                           ser_latch_o,
	output logic [NUM_CH-1:0]              dac_sel_o,
	output logic                           busy_o,
	output logic [`MDL_STATUS_W-1:0]       status_o,
	input  wire logic [1:0]                range_mode_i,
	output logic [2:0]                     range_sel_o
);
	localparam int XFER_CYC = `MDL_XFER_CYC;
	localparam int CW       = $clog2(XFER_CYC + 1);
	localparam int EW       = $bits(mdl_entry_type);
	localparam int LW       = $clog2(`MDL_BUF_DEPTH + 1);

	typedef struct packed {
		mdl_state_type           state;
		logic [CW-1:0]           cnt;
		logic [`MDL_CODE_W-1:0]  shreg;
		logic [`MDL_CODE_W-1:0]  word;
		logic                    ser_data;
		logic                    ser_bit;
		logic                    ser_latch;
		logic [NUM_CH-1:0]       sel;
		logic                    busy;
		logic [2:0]              range;
		logic [`MDL_CODE_W-1:0]  chk;
	} mdl_core_type;

	mdl_core_type  r;
	mdl_core_type  n;
	mdl_entry_type in_word;
	mdl_entry_type buf_word;
	logic          mapped;
	logic          accept;
	logic          buf_ready;
	logic          buf_valid;
	logic          pop;
	logic [LW-1:0] buf_level;
	logic [NUM_CH-1:0] chan_hit;
	logic          act;

	// Only even offsets that name an existing channel reach the buffer; the rest are dropped.
	// Ready does not depend on the offset, so a host cannot tell a dropped write from a taken one.
	always_comb begin
		in_word.chan = 4'(wr_addr_i / `MDL_CH_STRIDE);
		in_word.code = wr_data_i;
		mapped = !wr_addr_i[0] && (32'(in_word.chan) < NUM_CH);
		accept = wr_valid_i && mapped && buf_ready;
	end

	// Two words of slack mean a host that writes early loses nothing; it is merely held off.
	mdl_pair_buffer #(
		.WIDTH (EW),
		.DEPTH (`MDL_BUF_DEPTH)
	) i_mdl_pair_buffer (
		.clk_i       (clk_i),
		.rstn_i      (rstn_i),
		.in_valid_i  (wr_valid_i && mapped),
		.in_data_i   (in_word),
		.in_ready_o  (buf_ready),
		.out_valid_o (buf_valid),
		.out_data_o  (buf_word),
		.out_ready_i (pop),
		.level_o     (buf_level)
	);

	// One converter select per channel, so the current stage of channel n follows channel n.
	// With eight channels no select exists past channel seven; such offsets never reach the buffer.
	for (genvar i = 0; i < NUM_CH; i++) begin : g_sel
		assign chan_hit[i] = (buf_word.chan == 4'(i));
	end

	// Frame: sixteen bit slots MSB first, one latch slot, then settle to fill the transfer time.
	// Counter value 1 to 16 marks the bit slots, 17 the latch slot and 18 to 22 the settle slots.
	// The settle slots stretch the frame to the full transfer time, so a slow converter still
	// sees its select long enough; the price is idle cycles on the shared path.
	// A stalled converter only delays the start; once begun, a frame always runs to its end.
	// The select clears on the last edge, so two frames are always split by one quiet cycle.
	always_comb begin
		n = r;
		pop = 1'b0;
		n.ser_latch = 1'b0;
		case (r.state)
			MDL_IDLE: begin
				n.ser_bit = 1'b0;
				n.sel = '0;
				n.cnt = '0;
				if (buf_valid && dac_ready_i) begin
					pop = 1'b1;
					n.state = MDL_SHIFT;
					n.cnt = CW'(1);
					n.word = buf_word.code;
					n.ser_data = buf_word.code[`MDL_CODE_W-1];
					n.ser_bit = 1'b1;
					n.shreg = {buf_word.code[`MDL_CODE_W-2:0], 1'b0};
					n.sel = chan_hit;
				end
			end
			MDL_SHIFT: begin
				n.cnt = r.cnt + CW'(1);
				if (r.cnt == CW'(`MDL_CODE_W)) begin
					n.ser_bit = 1'b0;
					n.ser_latch = 1'b1;
					n.state = MDL_LATCH;
				end else begin
					n.ser_data = r.shreg[`MDL_CODE_W-1];
					n.shreg = {r.shreg[`MDL_CODE_W-2:0], 1'b0};
				end
			end
			MDL_LATCH: begin
				n.cnt = r.cnt + CW'(1);
				n.state = MDL_SETTLE;
			end
			MDL_SETTLE: begin
				if (r.cnt == CW'(XFER_CYC)) begin
					n.state = MDL_IDLE;
					n.cnt = '0;
					n.sel = '0;
				end else begin
					n.cnt = r.cnt + CW'(1);
				end
			end
			default: begin
				n.state = MDL_IDLE;
				n.cnt = '0;
				n.sel = '0;
				n.ser_bit = 1'b0;
			end
		endcase

		// Busy covers the accepted write, any word still buffered and the running frame.
		// Counting buffered words keeps the flag honest for a host that wrote early: it sees
		// busy until the last word it handed over has left the shifter.
		n.busy = accept || (n.state != MDL_IDLE) || (buf_level > LW'(pop));

		// A single range setting drives every current stage; unused code 0 keeps the last mode.
		// A new mode takes effect on the next edge from a flop, so the stages see no decode glitch.
		case (range_mode_i)
			`MDL_MODE_0_20: n.range = `MDL_SEL_0_20;
			`MDL_MODE_4_20: n.range = `MDL_SEL_4_20;
			`MDL_MODE_5_25: n.range = `MDL_SEL_5_25;
			default:        n.range = r.range;
		endcase

		// Checking aid: rebuilds the word from the strobed bits, the way a converter collects it.
		if (r.ser_bit) begin
			n.chk = {r.chk[`MDL_CODE_W-2:0], r.ser_data};
		end
	end

	// All control state lives in one register; reset leaves the path idle at the lowest range.
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			r <= '{state: MDL_IDLE, range: `MDL_RANGE_RST, default: '0};
		end else begin
			r <= n;
		end
	end

	// Every pin comes from a flop, so the converters and the host never see decode glitches.
	assign act = (r.state != MDL_IDLE);
	assign wr_ready_o = buf_ready;
	assign ser_data_o = r.ser_data;
	assign ser_bit_o = r.ser_bit;
	assign ser_latch_o = r.ser_latch;
	assign dac_sel_o = r.sel;
	assign busy_o = r.busy;
	assign range_sel_o = r.range;

	// Status word is read-only by construction: there is no write path to it.
	always_comb begin
		status_o = '0;
		status_o[`MDL_STATUS_BUSY] = r.busy;
	end

	default clocking mdl_cb @(posedge clk_i);
	endclocking
	default disable iff (!rstn_i);

	sequence s_frame_start;
		$rose(act);
	endsequence

	sequence s_sixteen_bits;
		ser_bit_o[*8] ##1 ser_bit_o[*8];
	endsequence

	sequence s_frame_tail;
		(ser_latch_o && !ser_bit_o) ##1 !ser_latch_o;
	endsequence

	// Outside a frame the serial side stays quiet, so no converter sees a stray strobe.
	sequence s_link_quiet;
		!ser_bit_o && !ser_latch_o && (dac_sel_o == '0);
	endsequence

	// A frame may start only from idle, with a word waiting and the converter path free.
	sequence s_start_allowed;
		!act && buf_valid && dac_ready_i;
	endsequence

	a_frame_bits: assert property (s_frame_start |-> s_sixteen_bits ##1 s_frame_tail)
		else $error("frame does not carry sixteen bits then one latch slot");
	a_frame_length: assert property (s_frame_start |-> ##21 act ##1 !act)
		else $error("frame length differs from the transfer time");
	a_code_intact: assert property (ser_latch_o |-> r.chk == r.word)
		else $error("shifted word differs from the code written");
	a_sign_first: assert property (s_frame_start |-> ser_data_o == r.word[`MDL_CODE_W-1])
		else $error("first bit is not the sign bit");
	a_busy_on_accept: assert property (accept |=> busy_o)
		else $error("busy did not rise after an accepted write");
	a_busy_in_frame: assert property (act |-> busy_o ##1 (busy_o || $past(r.cnt) == CW'(XFER_CYC)))
		else $error("busy dropped during a transfer");
	a_busy_release: assert property ((!act && buf_level == '0 && !accept) |=> !busy_o)
		else $error("busy stays high with nothing pending");
	a_odd_ignored: assert property ((wr_valid_i && wr_addr_i[0] && !pop) |=> buf_level == $past(buf_level))
		else $error("odd offset write was taken");
	a_range_mode2: assert property ((range_mode_i == `MDL_MODE_4_20) |=> range_sel_o == `MDL_SEL_4_20)
		else $error("mode 2 did not select the 4-20 range");
	a_range_hold: assert property ((range_mode_i == 2'h0) |=> $stable(range_sel_o))
		else $error("range changed without a valid mode");
	a_sel_steady: assert property ((act && $past(act)) |-> $onehot(dac_sel_o) && $stable(dac_sel_o))
		else $error("converter select not held one-hot through the frame");

	// Frame start, stall and the strobes around the latch slot.
	a_idle_quiet: assert property (!act |-> s_link_quiet)
		else $error("serial side active outside a frame");
	a_start_on_word: assert property (s_start_allowed |=> act)
		else $error("waiting word did not start a frame");
	a_stall_waits: assert property ((!act && !dac_ready_i) |=> !act)
		else $error("frame started while the converter path was stalled");
	a_first_bit_strobe: assert property (s_frame_start |-> ser_bit_o && !ser_latch_o)
		else $error("frame does not open with a bit slot");
	a_latch_after_bits: assert property ($fell(ser_bit_o) |-> ser_latch_o)
		else $error("bit strobe ended without the latch slot");
	a_latch_once: assert property (ser_latch_o |=> !ser_latch_o)
		else $error("latch pulse longer than one cycle");

	// Word and select: the code taken from the buffer reaches the converter named by its offset.
	a_word_taken: assert property (s_frame_start |-> r.word == $past(buf_word.code))
		else $error("frame does not carry the buffered code");
	a_word_kept: assert property ((act && $past(act)) |-> $stable(r.word))
		else $error("code changed during a frame");
	a_sel_onehot_start: assert property (s_frame_start |-> $onehot(dac_sel_o))
		else $error("frame opened without a single converter select");
	a_sel_chan: assert property (s_frame_start |-> dac_sel_o == (NUM_CH'(1) << $past(buf_word.chan)))
		else $error("frame selects a converter other than the one written");

	// Busy and status follow the buffer and the shifter, never the host's timing.
	a_pending_busy: assert property ((buf_level != '0) |-> busy_o)
		else $error("word waits in the buffer while busy is low");
	a_busy_low_idle: assert property (!busy_o |-> !act)
		else $error("frame runs while busy is low");
	a_busy_on_start: assert property (s_frame_start |-> busy_o)
		else $error("frame started without busy");
	a_status_mirror: assert property (status_o == {{(`MDL_STATUS_W-1){1'b0}}, busy_o})
		else $error("status word differs from the busy flag");
	a_ready_level: assert property (wr_ready_o |-> buf_level != LW'(`MDL_BUF_DEPTH))
		else $error("write port open while the buffer is full");
	a_drop_unmapped: assert property ((wr_valid_i && !mapped && !pop) |=> buf_level == $past(buf_level))
		else $error("unmapped write was taken");

	// Range select: every mode decodes to its own stage and one stage is always chosen.
	a_range_mode1: assert property ((range_mode_i == `MDL_MODE_0_20) |=> range_sel_o == `MDL_SEL_0_20)
		else $error("mode 1 did not select the 0-20 range");
	a_range_mode3: assert property ((range_mode_i == `MDL_MODE_5_25) |=> range_sel_o == `MDL_SEL_5_25)
		else $error("mode 3 did not select the 5-25 range");
	a_range_onehot: assert property ($onehot(range_sel_o))
		else $error("range select is not a single stage");

endmodule : mdl_dac_loader
`default_nettype wire

// *** mdl_map.svh ***
// Register offsets, field positions, reset values and timing counts of the channel loader.
`ifndef MDL_MAP_SVH
`define MDL_MAP_SVH

// Channel data ports sit at even byte offsets, channel n at offset n times the stride.
`define MDL_ADDR_W       5
`define MDL_CH_STRIDE    5'h02
`define MDL_CH_LAST_OFS  5'h1E
`define MDL_CHAN_MAX     16
`define MDL_CODE_W       16

// Status word: transfer-in-progress flag in bit zero, the rest reads as zero.
`define MDL_STATUS_W     16
`define MDL_STATUS_BUSY  0

// Clock period and serial transfer time, both in nanoseconds.
`define MDL_CLK_NS       100
`define MDL_XFER_NS      2200
`define MDL_XFER_CYC     ((`MDL_XFER_NS + `MDL_CLK_NS - 1) / `MDL_CLK_NS)

// Frame layout: one slot per code bit, then one latch slot.
`define MDL_LATCH_SLOT   (`MDL_CODE_W + 1)

// Current range modes and the one-hot range select they produce.
`define MDL_MODE_0_20    2'h1
`define MDL_MODE_4_20    2'h2
`define MDL_MODE_5_25    2'h3
`define MDL_SEL_0_20     3'h1
`define MDL_SEL_4_20     3'h2
`define MDL_SEL_5_25     3'h4
`define MDL_RANGE_RST    3'h1

// Depth of the buffer between the write port and the shifter.
`define MDL_BUF_DEPTH    2

`endif

// *** mdl_pair_buffer.sv ***
// Small valid/ready buffer that holds written channel codes until the shifter takes them.
`timescale 1ns/1ns
`default_nettype none
module mdl_pair_buffer #(
	parameter int WIDTH = 20,
	parameter int DEPTH = 2
) (
	input  wire logic                         clk_i,
	input  wire logic                         rstn_i,
	input  wire logic                         in_valid_i,
	input  wire logic [WIDTH-1:0]             in_data_i,
	output logic                              in_ready_o,
	output logic                              out_valid_o,
	output logic [WIDTH-1:0]                  out_data_o,
	input  wire logic                         out_ready_i,
	output logic [$clog2(DEPTH+1)-1:0]        level_o
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int LW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0]               wptr;
		logic [PW-1:0]               rptr;
		logic [LW-1:0]               level;
		logic                        rdy;
		logic                        nempty;
	} mdl_buf_type;

	mdl_buf_type r;
	mdl_buf_type n;
	logic        push;
	logic        pop;

	// Ready and valid are kept as flops so the writer never sees a combinational path.
	always_comb begin
		n = r;
		push = in_valid_i && r.rdy;
		pop = out_ready_i && r.nempty;
		if (push) begin
			n.mem[r.wptr] = in_data_i;
			n.wptr = (r.wptr == PW'(DEPTH - 1)) ? '0 : r.wptr + PW'(1);
		end
		if (pop) begin
			n.rptr = (r.rptr == PW'(DEPTH - 1)) ? '0 : r.rptr + PW'(1);
		end
		n.level = r.level + LW'(push) - LW'(pop);
		n.rdy = (n.level != LW'(DEPTH));
		n.nempty = (n.level != '0);
	end

	// Reset empties the buffer and opens the write side.
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			r <= '{rdy: 1'b1, default: '0};
		end else begin
			r <= n;
		end
	end

	assign in_ready_o = r.rdy;
	assign out_valid_o = r.nempty;
	assign out_data_o = r.mem[r.rptr];
	assign level_o = r.level;

	default clocking mdl_buf_cb @(posedge clk_i);
	endclocking
	default disable iff (!rstn_i);

	a_buf_full_level: assert property (!in_ready_o |-> level_o == LW'(DEPTH))
		else $error("buffer refuses writes while not full");
	a_buf_no_loss: assert property ((in_valid_i && in_ready_o && !pop) |=> level_o == $past(level_o) + LW'(1))
		else $error("accepted word not counted");

endmodule : mdl_pair_buffer
`default_nettype wire

// *** mdl_pkg.sv ***
// Types of the channel loader, among them the entry that waits in its buffer.
`default_nettype none
package mdl_pkg;

	// Shifter states, one-hot.
	typedef enum logic [3:0] {
		MDL_IDLE   = 4'h1,
		MDL_SHIFT  = 4'h2,
		MDL_LATCH  = 4'h4,
		MDL_SETTLE = 4'h8
	} mdl_state_type;

	// One accepted channel write as it waits in the buffer.
	typedef struct packed {
		logic [3:0]  chan;
		logic [15:0] code;
	} mdl_entry_type;

endpackage : mdl_pkg
`default_nettype wire

// *** testbench.sv ***
// Self-checking testbench of the channel loader with a converter model on its serial side.
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic        clk_i      = 1'b0;
	logic        rstn_i     = 1'b0;
	logic        wr_valid   = 1'b0;
	logic [4:0]  wr_addr    = 5'h00;
	logic [15:0] wr_data    = 16'h0000;
	logic [1:0]  range_mode = 2'h0;
	logic        stall      = 1'b0;
	logic        wr_ready, dac_ready, ser_data, ser_bit, ser_latch, busy;
	logic [15:0] dac_sel, status;
	logic [2:0]  range_sel;
	logic [7:0]  frame_len, bit_cnt;
	logic [15:0] corners [6] = '{16'h8000, 16'h7FFF, 16'h0000, 16'h4000, 16'hFFFF, 16'h8001};
	int          err_total   = 0;
	int          comparisons = 0;

	always #50 clk_i = ~clk_i;

	mdl_dac_loader #(.NUM_CH(16)) i_mdl_dac_loader (.clk_i(clk_i), .rstn_i(rstn_i), .wr_valid_i(wr_valid),
		.wr_addr_i(wr_addr), .wr_data_i(wr_data), .wr_ready_o(wr_ready), .dac_ready_i(dac_ready),
		.ser_data_o(ser_data), .ser_bit_o(ser_bit), .ser_latch_o(ser_latch), .dac_sel_o(dac_sel),
		.busy_o(busy), .status_o(status), .range_mode_i(range_mode), .range_sel_o(range_sel));

	mdl_conv_model #(.NUM_CH(16)) i_mdl_conv_model (.clk_i(clk_i), .rstn_i(rstn_i), .ser_data_i(ser_data),
		.ser_bit_i(ser_bit), .ser_latch_i(ser_latch), .dac_sel_i(dac_sel), .stall_i(stall),
		.dac_ready_o(dac_ready), .frame_len_o(frame_len), .bit_cnt_o(bit_cnt));

	// One-hot range select expected for a range mode.
	function automatic logic [15:0] exp_range(input logic [1:0] mode);
		return 16'h0001 << (mode - 2'h1);
	endfunction : exp_range

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : tally_and_finish

	// Inputs always change the same small delay after the rising edge.
	task automatic step;
		@(posedge clk_i);
		#10;
	endtask : step

	// Holds the request until an edge samples ready high; gives up after a bounded wait.
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		int n;
		n = 0;
		wr_valid = 1'b1;
		wr_addr  = a;
		wr_data  = d;
		@(posedge clk_i);
		while (wr_ready !== 1'b1) begin
			n++;
			if (n > 100) begin
				err_total++;
				tally_and_finish();
			end
			@(posedge clk_i);
		end
		#10;
		wr_valid = 1'b0;
	endtask : wr

	// Waits for busy to fall and returns how many cycles it was seen high.
	task automatic wait_idle(output int n);
		n = 0;
		while (busy === 1'b1 && n < 200) begin
			n++;
			step();
		end
		if (n >= 200) begin
			err_total++;
			tally_and_finish();
		end
	endtask : wait_idle

	// One write on an idle path, then timing, status and the converted word.
	task automatic xfer(input logic [3:0] ch, input logic [15:0] code);
		int n;
		wr({ch, 1'b0}, code);
		chk(status, 16'h0001);
		wait_idle(n);
		chk(n[15:0], 16'h0017);
		chk(status, 16'h0000);
		// The model posts the frame length one edge after the select drops.
		step();
		chk({8'h00, frame_len}, 16'h0016);
		chk({8'h00, bit_cnt}, 16'h0010);
		chk(i_mdl_conv_model.mem[ch], code);
	endtask : xfer

	initial begin
		int n;
		logic [15:0] a;
		logic [15:0] b;
		void'($urandom(32'hD20838C4));
		repeat (2) @(posedge clk_i);
		#10 rstn_i = 1'b1;
		chk(status, 16'h0000);
		chk({12'h000, wr_ready, range_sel}, 16'h0009);
		$display("test reset done");
		// Full-scale ends, zero, half-scale, minus one and one above minus full scale, spread over the channels.
		for (int i = 0; i < 6; i++) begin
			xfer(4'(i * 3), corners[i]);
		end
		repeat (12) xfer(4'($urandom_range(15)), 16'($urandom));
		$display("test codes done");
		// Stalled converter: two words buffered, write port closed while full, both delivered later.
		a = 16'($urandom);
		b = ~a;
		stall = 1'b1;
		wr(5'h04, a);
		step();
		wr(5'h06, b);
		chk({15'h0000, wr_ready}, 16'h0000);
		repeat (5) step();
		chk(dac_sel, 16'h0000);
		chk(status, 16'h0001);
		stall = 1'b0;
		wait_idle(n);
		chk(i_mdl_conv_model.mem[2], a);
		chk(i_mdl_conv_model.mem[3], b);
		$display("test stall done");
		// An odd offset is not a channel port and starts nothing.
		wr(5'h05, 16'h1234);
		chk(status, 16'h0000);
		repeat (25) step();
		chk(i_mdl_conv_model.mem[2], a);
		$display("test unmapped done");
		// Every range mode, then mode zero keeps the last selection.
		for (int m = 1; m < 4; m++) begin
			range_mode = 2'(m);
			step();
			chk({13'h0000, range_sel}, exp_range(2'(m)));
		end
		range_mode = 2'h0;
		repeat (2) step();
		chk({13'h0000, range_sel}, 16'h0004);
		$display("test range done");
		tally_and_finish();
	end
endmodule : testbench
`default_nettype wire
